// ==== dv/tb_top.sv ====
/*
  self-checking bench: five crate ends and the combiner on one link.
  assumes the combiner is the only ahb-lite slave and answers with no wait state.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                         hclk = 1'b0;
  logic                         hresetn = 1'b0;
  logic                         hsel = 1'b0;
  logic [31:0]                  haddr = 32'h00000000;
  logic [1:0]                   htrans = 2'h0;
  logic                         hwrite = 1'b0;
  logic [2:0]                   hsize = 3'h2;
  logic [31:0]                  hwdata = 32'h00000000;
  logic [31:0]                  hrdata;
  logic                         hreadyout;
  logic                         hresp;
  logic [tboc_pkg::NBITS-1:0]   tin [tboc_pkg::NCRATE] = '{default: '0};
  logic [tboc_pkg::NBITS-1:0]   tout [tboc_pkg::NCRATE];
  logic                         lo0, lo1, lo2, lo3, lo4, lo5;
  int                           fails = 0;
  int                           total_checks = 0;

  tboc_if link ();
  for (genvar g = 0; g < tboc_pkg::NCRATE; g++) begin : g_cr
    tboc_crate #(.CRATE(g)) i_tboc_crate (.hclk(hclk), .hresetn(hresetn), .link(link),
      .trig_in(tin[g]), .trig_out(tout[g]));
  end
  tboc_combiner i_tboc_combiner (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link),
    .cluster_or_output(lo0), .scintillator_cosmic_output(lo1), .column_cosmic_or_output(lo2),
    .column_cosmic_and_output(lo3), .light_pulser_output(lo4), .pair_trigger_output(lo5));
  tboc_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .trig_bits(link.trig_bits),
    .trigger_pulse_width(link.trigger_pulse_width), .cluster_or_output(lo0),
    .scintillator_cosmic_output(lo1), .column_cosmic_or_output(lo2),
    .column_cosmic_and_output(lo3), .light_pulser_output(lo4), .pair_trigger_output(lo5));

  always #20 hclk = ~hclk;

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // bounded wait for hready; a hang ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    check(what, q, exp);
    check("okay response", {31'h00000000, hresp}, 32'h00000000);
  endtask

  task automatic t_regs;
    rchk("latency", 8'h00, 32'(tboc_pkg::RST_LATENCY));
    rchk("width", 8'h04, 32'(tboc_pkg::RST_WIDTH));
    rchk("select", 8'h08, {21'h0, tboc_pkg::RST_PULSER, 5'h00, tboc_pkg::RST_SCINT});
    rchk("delay5", 8'h34, 32'(tboc_pkg::RST_DELAY));
    rchk("presc5", 8'h54, 32'(tboc_pkg::RST_PRESC));
    rchk("unmapped", 8'h80, 32'h00000000);
    // latency kept above the minimum path time; small width for edge-sensitive use downstream
    wreg(8'h00, 32'h0000003c);
    wreg(8'h04, 32'h00000003);
    wreg(8'h20, 32'h00000005);
    rchk("width set", 8'h04, 32'h00000003);
    rchk("latency set", 8'h00, 32'h0000003c);
  endtask
  // latency 60 plus delay 5 on bit 0, then a width of 3
  task automatic t_lat;
    int n;
    int w;
    @(posedge hclk);
    tin[0][0] <= 1'b1;
    n = 0;
    do begin
      @(posedge hclk);
      tin[0][0] <= 1'b0;
      n++;
      #1;
    end while (tout[0][0] !== 1'b1 && n < 100);
    check("latency cycles", 32'(n), 32'd67);
    w = 0;
    while (tout[0][0] === 1'b1 && w < 300) begin
      w++;
      @(posedge hclk);
      #1;
    end
    check("pulse width", 32'(w), 32'd3);
  endtask
  // prescale 3 on bit 1: six edges on the designated crate give two
  // pulser line follows only the designated crate, not crate 0
  task automatic t_presc;
    int r;
    int p;
    logic prev;
    wreg(8'h44, 32'h00000003);
    r = 0;
    p = 0;
    prev = 1'b0;
    for (int i = 0; i < 120; i++) begin
      @(posedge hclk);
      tin[2][1] <= (i % 10 == 0 && i < 60);
      tin[0][5] <= (i % 10 == 0 && i < 60);
      tin[2][5] <= (i == 5);
      #1;
      r += int'(lo1 === 1'b1 && prev === 1'b0);
      p += int'(lo4 === 1'b1);
      prev = lo1;
    end
    check("scint edges", 32'(r), 32'd2);
    check("pulser designated crate", 32'(p), 32'd3);
  endtask
  // column lines: all crates, then two crates; cluster line from crate 1
  task automatic t_lines;
    int h0;
    int h2;
    int h3;
    h0 = 0;
    h2 = 0;
    h3 = 0;
    for (int i = 0; i < 100; i++) begin
      @(posedge hclk);
      for (int c = 0; c < tboc_pkg::NCRATE; c++) begin
        tin[c][2] <= (i == 0) || (i == 20 && c < 2);
      end
      tin[1][0] <= (i == 0);
      #1;
      h0 += int'(lo0 === 1'b1);
      h2 += int'(lo2 === 1'b1);
      h3 += int'(lo3 === 1'b1);
    end
    check("cluster or cycles", 32'(h0), 32'd3);
    check("column or cycles", 32'(h2), 32'd6);
    check("column and cycles", 32'(h3), 32'd3);
  endtask
  task automatic pair_case(input logic [4:0] m3, input logic [4:0] m4, input int exp);
    int h;
    @(posedge hclk);
    for (int c = 0; c < tboc_pkg::NCRATE; c++) begin
      tin[c][3] <= m3[c];
      tin[c][4] <= m4[c];
    end
    h = 0;
    for (int i = 0; i < 80; i++) begin
      @(posedge hclk);
      for (int c = 0; c < tboc_pkg::NCRATE; c++) begin
        tin[c][3] <= 1'b0;
        tin[c][4] <= 1'b0;
      end
      #1;
      h += int'(lo5 === 1'b1);
    end
    check("pair high cycles", 32'(h), 32'(exp));
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    // crate outputs stay quiet while the history fills
    repeat (2100) @(posedge hclk);
    t_lat();
    t_presc();
    t_lines();
    pair_case(5'h03, 5'h00, 5);
    pair_case(5'h01, 5'h00, 0);
    pair_case(5'h00, 5'h10, 3);
    pair_case(5'h15, 5'h00, 5);
    rchk("pair count", tboc_pkg::OFS_PAIRCNT, 32'h00000003);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire

// ==== dv/tboc_asserts.sv ====
/*
  concurrent checks on the crate link and the counting-room lines.
  assumes five crate ends, one hclk, and the pair pulse of three cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tboc_asserts (
  // clock and reset
  input wire logic                                        hclk,
  input wire logic                                        hresetn,
  // crate link
  input wire logic [tboc_pkg::NBITS-1:0]                  trig_bits [tboc_pkg::NCRATE],
  input wire logic [tboc_pkg::WID_W-1:0]                  trigger_pulse_width,
  // counting-room lines
  input wire logic                                        cluster_or_output,
  input wire logic                                        scintillator_cosmic_output,
  input wire logic                                        column_cosmic_or_output,
  input wire logic                                        column_cosmic_and_output,
  input wire logic                                        light_pulser_output,
  input wire logic                                        pair_trigger_output
);
  logic [tboc_pkg::NCRATE-1:0] b0, b1, b2, b4, b5;
  int                          n3;
  logic [8:0]                  run_q;
  logic [8:0]                  run_d;

  always_comb begin
    n3 = 0;
    for (int c = 0; c < tboc_pkg::NCRATE; c++) begin
      b0[c] = trig_bits[c][0];
      b1[c] = trig_bits[c][1];
      b2[c] = trig_bits[c][2];
      b4[c] = trig_bits[c][4];
      b5[c] = trig_bits[c][5];
      n3 += int'(trig_bits[c][3]);
    end
  end

  // run length of crate 0 pair bit; saturation not needed for the short widths used
  always_comb run_d = trig_bits[0][3] ? run_q + 9'h001 : 9'h000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) run_q <= 9'h000;
    else run_q <= run_d;
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_coinc;
    n3 >= 2;
  endsequence
  sequence s_quiet;
    (n3 < 2) [*3] ##1 (n3 < 2 && b4 == '0);
  endsequence

  a_cluster_or: assert property (cluster_or_output == |b0)
    else $error("cluster line differs from or of bit 0");
  a_column_or: assert property (column_cosmic_or_output == |b2)
    else $error("column or line differs from or of bit 2");
  a_column_and: assert property (column_cosmic_and_output == &b2)
    else $error("column and line differs from and of bit 2");
  a_scint_source: assert property (scintillator_cosmic_output |-> |b1)
    else $error("scintillator line high with no bit 1");
  a_pulser_source: assert property (light_pulser_output |-> |b5)
    else $error("pulser line high with no bit 5");
  a_pair_crate: assert property (|b4 |-> pair_trigger_output)
    else $error("pair line low with a bit 4 high");
  a_pair_pulse: assert property (s_coinc |=> pair_trigger_output [*3])
    else $error("pair pulse shorter than three cycles");
  a_pair_end: assert property (s_quiet |-> !pair_trigger_output)
    else $error("pair pulse outlasts its window");
  a_width_min: assert property ($fell(trig_bits[0][3]) |->
      run_q >= ((trigger_pulse_width == '0) ? 9'h001 : {1'b0, trigger_pulse_width}))
    else $error("crate pulse shorter than the set width");
endmodule // tboc_asserts
`default_nettype wire

// ==== hdl/tboc_combiner.sv ====
/*
  combiner end: merges crate trigger bits into six counting-room lines and holds
  the settings broadcast to every crate, reached over ahb-lite.
  assumes every crate bit synchronous to hclk; one slave on the bus.
*/
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module tboc_combiner #(
  parameter int NCR = tboc_pkg::NCRATE
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // crate link
  tboc_if.comb             link,
  // counting-room lines
  output logic             cluster_or_output,
  output logic             scintillator_cosmic_output,
  output logic             column_cosmic_or_output,
  output logic             column_cosmic_and_output,
  output logic             light_pulser_output,
  output logic             pair_trigger_output
);
  localparam int NB = tboc_pkg::NBITS;
  localparam logic [3:0] PAIR_LOAD = 4'(tboc_pkg::PAIR_PULSE_CYC);

  // count of set bits, used for the pair multiplicity
  function automatic logic [3:0] ones(input logic [NCR-1:0] v);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < NCR; i++) begin
      n = n + 4'(v[i]);
    end
    return n;
  endfunction

  // settings
  logic [tboc_pkg::LAT_W-1:0]         lat_q, lat_d;
  logic [tboc_pkg::WID_W-1:0]         wid_q, wid_d;
  logic [tboc_pkg::SEL_W-1:0]         scs_q, scs_d, pls_q, pls_d;
  logic [NB-1:0][tboc_pkg::DLY_W-1:0] dly_q, dly_d;
  logic [NB-1:0][tboc_pkg::PS_W-1:0]  ps_q, ps_d;
  // bus state
  logic                               wpend_q, wpend_d;
  logic [7:0]                         waddr_q, waddr_d;
  logic [31:0]                        rdata_q, rdata_d;
  // pair pulse
  logic [3:0]                         ppul_q, ppul_d;
  logic [31:0]                        pcnt_q, pcnt_d;
  logic                               pair_prev_q, pair_prev_d;
  // merged bits
  logic [NCR-1:0]                     b0, b2, b3, b4;
  logic [NB-1:0]                      lines;
  logic                               coinc, pair_line;
  logic                               take;
  logic [7:0]                         ofs;

  always_comb begin
    for (int c = 0; c < NCR; c++) begin
      b0[c] = link.trig_bits[c][tboc_pkg::BIT_CLUSTER];
      b2[c] = link.trig_bits[c][tboc_pkg::BIT_COLUMN];
      b3[c] = link.trig_bits[c][tboc_pkg::BIT_PAIR_SINGLE];
      b4[c] = link.trig_bits[c][tboc_pkg::BIT_PAIR_CRATE];
    end
  end

  // no edge detection or reshaping on these five lines
  assign cluster_or_output          = |b0;
  assign scintillator_cosmic_output =
    (32'(scs_q) < NCR) ? link.trig_bits[scs_q][tboc_pkg::BIT_SCINT] : 1'b0;
  assign column_cosmic_or_output    = |b2;
  assign column_cosmic_and_output   = &b2;
  assign light_pulser_output        =
    (32'(pls_q) < NCR) ? link.trig_bits[pls_q][tboc_pkg::BIT_PULSER] : 1'b0;

  // overlap window comes only from the crate stretch width
  assign coinc = (ones(b3) >= 4'd2);
  assign pair_line = (|b4) | (ppul_q != '0);
  assign pair_trigger_output = pair_line;

  // pair pulse, retriggered each cycle the coincidence holds
  always_comb begin
    ppul_d = ppul_q;
    if (coinc) begin
      ppul_d = PAIR_LOAD;
    end else if (ppul_q != '0) begin
      ppul_d = ppul_q - 1'b1;
    end
    pair_prev_d = pair_line;
    pcnt_d = pcnt_q + 32'(pair_line & ~pair_prev_q);
  end

  assign lines = {pair_line, light_pulser_output, column_cosmic_and_output,
                  column_cosmic_or_output, scintillator_cosmic_output, cluster_or_output};

  // bus: zero wait states, write lands one cycle after its address phase
  assign take = hsel & hready & htrans[1];
  assign ofs  = haddr[7:0];

  always_comb begin
    lat_d = lat_q;
    wid_d = wid_q;
    scs_d = scs_q;
    pls_d = pls_q;
    dly_d = dly_q;
    ps_d  = ps_q;
    wpend_d = take & hwrite;
    waddr_d = take ? ofs : waddr_q;
    rdata_d = rdata_q;
    if (wpend_q) begin
      case (waddr_q)
        tboc_pkg::OFS_LATENCY: begin
          lat_d = hwdata[tboc_pkg::LAT_W-1:0];
        end
        tboc_pkg::OFS_WIDTH: begin
          wid_d = hwdata[tboc_pkg::WID_W-1:0];
        end
        tboc_pkg::OFS_SELECT: begin
          scs_d = hwdata[tboc_pkg::SEL_W-1:0];
          pls_d = hwdata[8 +: tboc_pkg::SEL_W];
        end
        default: begin
          for (int b = 0; b < NB; b++) begin
            if (waddr_q == tboc_pkg::OFS_DELAY0 + 8'(4 * b)) begin
              dly_d[b] = hwdata[tboc_pkg::DLY_W-1:0];
            end
            if (waddr_q == tboc_pkg::OFS_PRESC0 + 8'(4 * b)) begin
              ps_d[b] = hwdata[tboc_pkg::PS_W-1:0];
            end
          end
        end
      endcase
    end
    if (take && !hwrite) begin
      rdata_d = '0;
      case (ofs)
        tboc_pkg::OFS_LATENCY: rdata_d = 32'(lat_q);
        tboc_pkg::OFS_WIDTH:   rdata_d = 32'(wid_q);
        tboc_pkg::OFS_SELECT:  rdata_d = {21'h0, pls_q, 5'h0, scs_q};
        tboc_pkg::OFS_STATUS:  rdata_d = 32'(lines);
        tboc_pkg::OFS_PAIRCNT: rdata_d = pcnt_q;
        default: begin
          for (int b = 0; b < NB; b++) begin
            if (ofs == tboc_pkg::OFS_DELAY0 + 8'(4 * b)) begin
              rdata_d = 32'(dly_q[b]);
            end
            if (ofs == tboc_pkg::OFS_PRESC0 + 8'(4 * b)) begin
              rdata_d = 32'(ps_q[b]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat_q       <= tboc_pkg::RST_LATENCY;
      wid_q       <= tboc_pkg::RST_WIDTH;
      scs_q       <= tboc_pkg::RST_SCINT;
      pls_q       <= tboc_pkg::RST_PULSER;
      dly_q       <= {NB{tboc_pkg::RST_DELAY}};
      ps_q        <= {NB{tboc_pkg::RST_PRESC}};
      wpend_q     <= 1'b0;
      waddr_q     <= '0;
      rdata_q     <= '0;
      ppul_q      <= '0;
      pcnt_q      <= '0;
      pair_prev_q <= 1'b0;
    end else begin
      lat_q       <= lat_d;
      wid_q       <= wid_d;
      scs_q       <= scs_d;
      pls_q       <= pls_d;
      dly_q       <= dly_d;
      ps_q        <= ps_d;
      wpend_q     <= wpend_d;
      waddr_q     <= waddr_d;
      rdata_q     <= rdata_d;
      ppul_q      <= ppul_d;
      pcnt_q      <= pcnt_d;
      pair_prev_q <= pair_prev_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // settings broadcast to every crate
  assign link.trigger_output_latency  = lat_q;
  assign link.trigger_pulse_width     = wid_q;
  assign link.per_bit_trigger_delay   = dly_q;
  assign link.trigger_prescale_factor = ps_q;
endmodule // tboc_combiner
`default_nettype wire

// ==== hdl/tboc_crate.sv ====
/*
  crate end: delays, prescales and stretches the six local trigger bits.
  assumes trig_in synchronous to hclk and settings stable while triggers flow.
*/
`timescale 1ns/1ps
`default_nettype none
module tboc_crate #(
  parameter int CRATE = 0
) (
  // clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // link to the combiner
  tboc_if.crate                           link,
  // local trigger bits
  input  wire logic [tboc_pkg::NBITS-1:0] trig_in,
  output logic      [tboc_pkg::NBITS-1:0] trig_out
);
  localparam int NB = tboc_pkg::NBITS;

  logic [NB-1:0]                      ring [2**tboc_pkg::BUF_W];
  logic [tboc_pkg::BUF_W-1:0]         wptr_q, wptr_d;
  logic                               primed_q, primed_d;
  logic [NB-1:0]                      del_q, del_d, prev_q, prev_d, out_q, out_d;
  logic [NB-1:0][tboc_pkg::PS_W-1:0]  pcnt_q, pcnt_d;
  logic [NB-1:0][tboc_pkg::WID_W-1:0] wcnt_q, wcnt_d;
  logic [tboc_pkg::BUF_W-1:0]         back;
  logic                               fire;

  // history write; no reset so it maps to block memory
  always_ff @(posedge hclk) begin
    ring[wptr_q] <= trig_in;
  end

  always_comb begin
    wptr_d = wptr_q + 1'b1;
    primed_d = primed_q | (&wptr_q);
    prev_d = del_q;
    pcnt_d = pcnt_q;
    wcnt_d = wcnt_q;
    out_d = '0;
    del_d = '0;
    back = '0;
    fire = 1'b0;
    for (int b = 0; b < NB; b++) begin
      // common latency plus this bit's own delay, read back from history
      back = tboc_pkg::BUF_W'(link.trigger_output_latency)
           + tboc_pkg::BUF_W'(link.per_bit_trigger_delay[b]);
      if (back == '0) begin
        back = tboc_pkg::BUF_W'(1);
      end
      // ring content is unknown until one full lap has been written
      del_d[b] = primed_q & ring[wptr_q - back][b];
      // one of every n rising edges passes, counter per bit
      fire = 1'b0;
      if (del_q[b] && !prev_q[b]) begin
        if (pcnt_q[b] + 1'b1 >= link.trigger_prescale_factor[b]) begin
          fire = 1'b1;
          pcnt_d[b] = '0;
        end else begin
          pcnt_d[b] = pcnt_q[b] + 1'b1;
        end
      end
      // retriggerable stretch, common width
      if (fire) begin
        wcnt_d[b] = (link.trigger_pulse_width == '0) ? tboc_pkg::WID_W'(1)
                                                     : link.trigger_pulse_width;
      end else if (wcnt_q[b] != '0) begin
        wcnt_d[b] = wcnt_q[b] - 1'b1;
      end
      out_d[b] = (wcnt_d[b] != '0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wptr_q   <= '0;
      primed_q <= 1'b0;
      del_q    <= '0;
      prev_q   <= '0;
      pcnt_q   <= '0;
      wcnt_q   <= '0;
      out_q    <= '0;
    end else begin
      wptr_q   <= wptr_d;
      primed_q <= primed_d;
      del_q    <= del_d;
      prev_q   <= prev_d;
      pcnt_q   <= pcnt_d;
      wcnt_q   <= wcnt_d;
      out_q    <= out_d;
    end
  end

  // bit positions follow the fixed map in the package
  assign trig_out              = out_q;
  assign link.trig_bits[CRATE] = out_q;
endmodule // tboc_crate
`default_nettype wire

// ==== inc/tboc_if.sv ====
/*
  link between the crate trigger ends and the combiner.
  assumes all parties on hclk; settings are broadcast from the combiner to every crate.
*/
`timescale 1ns/1ps
`default_nettype none
interface tboc_if;
  logic [tboc_pkg::NBITS-1:0]                     trig_bits [tboc_pkg::NCRATE];
  logic [tboc_pkg::LAT_W-1:0]                     trigger_output_latency;
  logic [tboc_pkg::WID_W-1:0]                     trigger_pulse_width;
  logic [tboc_pkg::NBITS-1:0][tboc_pkg::DLY_W-1:0] per_bit_trigger_delay;
  logic [tboc_pkg::NBITS-1:0][tboc_pkg::PS_W-1:0]  trigger_prescale_factor;

  modport crate (
    output trig_bits,
    input  trigger_output_latency,
    input  trigger_pulse_width,
    input  per_bit_trigger_delay,
    input  trigger_prescale_factor
  );
  modport comb (
    input  trig_bits,
    output trigger_output_latency,
    output trigger_pulse_width,
    output per_bit_trigger_delay,
    output trigger_prescale_factor
  );
endinterface
`default_nettype wire

// ==== inc/tboc_pkg.sv ====
/*
  package of the trigger bit output combiner: widths, bit map, register map, reset values.
  assumes a 25 MHz hclk shared by every crate end and the combiner.
*/
`default_nettype none
package tboc_pkg;
  // trigger bit assignment on each crate output
  localparam int BIT_CLUSTER     = 0;
  localparam int BIT_SCINT       = 1;
  localparam int BIT_COLUMN      = 2;
  localparam int BIT_PAIR_SINGLE = 3;
  localparam int BIT_PAIR_CRATE  = 4;
  localparam int BIT_PULSER      = 5;
  localparam int NBITS           = 6;
  localparam int NCRATE          = 5;

  // field widths of the settings
  localparam int LAT_W = 10;
  localparam int DLY_W = 8;
  localparam int PS_W  = 16;
  localparam int WID_W = 8;
  localparam int BUF_W = 11;
  localparam int SEL_W = 3;

  // clock and timing
  localparam int CLK_PERIOD_PS   = 40000;
  localparam int PAIR_PULSE_NS   = 100;
  localparam int PAIR_PULSE_CYC  = (PAIR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MIN_LATENCY_NS  = 2300;
  localparam int MIN_LATENCY_CYC = (MIN_LATENCY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // register byte offsets
  localparam logic [7:0] OFS_LATENCY = 8'h00;
  localparam logic [7:0] OFS_WIDTH   = 8'h04;
  localparam logic [7:0] OFS_SELECT  = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_PAIRCNT = 8'h10;
  localparam logic [7:0] OFS_DELAY0  = 8'h20;
  localparam logic [7:0] OFS_PRESC0  = 8'h40;

  // values after reset
  localparam logic [LAT_W-1:0] RST_LATENCY = 10'(MIN_LATENCY_CYC);
  localparam logic [WID_W-1:0] RST_WIDTH   = 8'h04;
  localparam logic [DLY_W-1:0] RST_DELAY   = 8'h00;
  localparam logic [PS_W-1:0]  RST_PRESC   = 16'h0001;
  localparam logic [SEL_W-1:0] RST_SCINT   = 3'h2;
  localparam logic [SEL_W-1:0] RST_PULSER  = 3'h2;
endpackage
`default_nettype wire
